/* dv/dual_slope_pwm_timer8_bench.sv */
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps
module dual_slope_pwm_timer8_bench;
  import pwm_timer8_pkg::*;
  logic       sys_clk = 1'b0, arst_n = 1'b0, waveformModeHighBit = 1'b0;
  reg_req_t   regReq = '0;
  clk_sel_t   clkSel = CLK_STOP;
  logic [7:0] compareValueA = 8'h00, compareValueB = 8'h00, regRdata, counterValue;
  logic       pinDirOutA = 1'b0, pinDirOutB = 1'b0, overflowFlagClr = 1'b0;
  logic       matchFlagAClr = 1'b0, matchFlagBClr = 1'b0;
  logic       overflowFlag, matchFlagA, matchFlagB, compareOutputA, compareOutputB;
  logic       pinOutA, pinOeA_n, pinOutB, pinOeB_n;
  int         nErrors = 0, samplesChecked = 0;
  always #4 sys_clk = ~sys_clk;
  dual_slope_pwm_timer8 uut (.sys_clk, .arst_n, .regReq, .regRdata, .waveformModeHighBit,
    .clkSel, .compareValueA, .compareValueB, .pinDirOutA, .pinDirOutB, .overflowFlagClr,
    .matchFlagAClr, .matchFlagBClr, .counterValue, .overflowFlag, .matchFlagA, .matchFlagB,
    .compareOutputA, .compareOutputB, .pinOutA, .pinOeA_n, .pinOutB, .pinOeB_n);
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      nErrors++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wreg(logic io, logic [7:0] a, logic [7:0] d);
    regReq = '{wr: 1'b1, rd: 1'b0, ioSpace: io, addr: a, wdata: d};
    cyc(1);
  endtask
  task automatic rreg(logic io, logic [7:0] a, logic [7:0] e);
    regReq = '{wr: 1'b0, rd: 1'b1, ioSpace: io, addr: a, wdata: 8'h00};
    #1 chk("ctrl", {8'h00, e}, {8'h00, regRdata});
    cyc(1);
  endtask
  // one period, from an arrival at bottom to the next; high time counted in cycles
  task automatic measure(output int len, output int hiA, output int hiB, output int mx);
    logic seen1;
    seen1 = 1'b0;
    len = 0;
    hiA = 0;
    hiB = 0;
    mx = 0;
    do begin
      cyc(1);
      len++;
      hiA += int'(compareOutputA === 1'b1);
      hiB += int'(compareOutputB === 1'b1);
      if (int'(counterValue) > mx) mx = int'(counterValue);
      if (counterValue === 8'h01) seen1 = 1'b1;
    end while (!(seen1 && counterValue === 8'h00) && len < 20000);
  endtask
  task automatic run(logic hb, logic [1:0] aA, logic [1:0] aB, logic [7:0] ca,
                     logic [7:0] cb, clk_sel_t cs, int dv);
    int len, hiA, hiB, mx, per;
    logic o0;
    compareValueA = ca;
    compareValueB = cb;
    waveformModeHighBit = hb;
    clkSel = cs;
    pinDirOutA = 1'($urandom);
    pinDirOutB = ~pinDirOutA;
    wreg(1'b0, 8'h44, {aA, aB, 4'h1});
    regReq = '0;
    // two periods so the buffered compare values are live
    repeat (2) measure(len, hiA, hiB, mx);
    o0 = compareOutputA;
    measure(len, hiA, hiB, mx);
    per = hb ? 2 * int'(ca) : 510;
    chk("period", 16'(per * dv), 16'(len));
    chk("top", 16'(per / 2), 16'(mx));
    chk("highB", 16'((aB == 2'h3 ? per - 2 * cb : 2 * cb) * dv), 16'(hiB));
    chk("oeA", {15'h0, ~pinDirOutA}, {15'h0, pinOeA_n});
    chk("oeB", {15'h0, ~pinDirOutB}, {15'h0, pinOeB_n});
    chk("pinA", {15'h0, compareOutputA}, {15'h0, pinOutA});
    chk("pinB", {15'h0, compareOutputB}, {15'h0, pinOutB});
    if (hb) chk("toggleA", {15'h0, ~o0}, {15'h0, compareOutputA});
    else chk("highA", 16'((aA == 2'h3 ? per - 2 * ca : 2 * ca) * dv), 16'(hiA));
    $display("test done mode high %0d actions %0h %0h", hb, aA, aB);
  endtask
  initial begin
    void'($urandom(32'h9C045CB7));
    cyc(5);
    arst_n = 1'b1;
    rreg(1'b0, 8'h44, 8'h00);
    wreg(1'b0, 8'h44, 8'hFF);
    rreg(1'b0, 8'h44, 8'hF3);
    wreg(1'b0, 8'h45, 8'h00);
    rreg(1'b0, 8'h24, 8'h00);
    wreg(1'b1, 8'h24, 8'h5A);
    rreg(1'b1, 8'h24, 8'h52);
    regReq = '0;
    $display("test done register access");
    run(1'b0, 2'h2, 2'h3, 8'h00, 8'($urandom_range(254, 1)), CLK_D1, 1);
    run(1'b0, 2'h3, 2'h2, 8'hFF, 8'($urandom_range(254, 1)), CLK_D1, 1);
    run(1'b0, 2'h2, 2'h2, 8'hFF, 8'h00, CLK_D8, 8);
    chk("ovfSet", 16'h1, {15'h0, overflowFlag});
    chk("matchA", 16'h1, {15'h0, matchFlagA});
    chk("matchB", 16'h1, {15'h0, matchFlagB});
    overflowFlagClr = 1'b1;
    matchFlagAClr = 1'b1;
    cyc(1);
    overflowFlagClr = 1'b0;
    matchFlagAClr = 1'b0;
    chk("ovfClr", 16'h0, {15'h0, overflowFlag});
    chk("matchAClr", 16'h0, {15'h0, matchFlagA});
    run(1'b1, 2'h1, 2'h3, 8'($urandom_range(200, 100)), 8'($urandom_range(90, 1)),
        CLK_D1, 1);
    chk("ovfAgain", 16'h1, {15'h0, overflowFlag});
    clkSel = CLK_STOP;
    cyc(20);
    tally_and_finish();
  end
  initial begin
    #400000;
    nErrors++;
    tally_and_finish();
  end
endmodule

/* dv/dual_slope_pwm_timer8_monitor.sv */
// assertion checker bound to the dual-slope pwm timer
`timescale 1ns/1ps
module dual_slope_pwm_timer8_monitor
  import pwm_timer8_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic             sys_clk,
  input wire logic             arst_n,
  input wire reg_req_t         regReq,
  input wire logic [7:0]       regRdata,
  input wire logic             waveformModeHighBit,
  input wire clk_sel_t         clkSel,
  input wire logic [CNT_W-1:0] compareValueA,
  input wire logic [CNT_W-1:0] compareValueB,
  input wire logic             pinDirOutA,
  input wire logic             pinDirOutB,
  input wire logic             overflowFlagClr,
  input wire logic             matchFlagAClr,
  input wire logic             matchFlagBClr,
  input wire logic [CNT_W-1:0] counterValue,
  input wire logic             overflowFlag,
  input wire logic             matchFlagA,
  input wire logic             matchFlagB,
  input wire logic             compareOutputA,
  input wire logic             compareOutputB,
  input wire logic             pinOutA,
  input wire logic             pinOeA_n,
  input wire logic             pinOutB,
  input wire logic             pinOeB_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_oe_dir_a:
    assert property (!pinDirOutA |-> pinOeA_n) else $error("pin A driven as input");
  a_oe_dir_b:
    assert property (!pinDirOutB |-> pinOeB_n) else $error("pin B driven as input");
  a_ovf_at_bottom:
    assert property ((counterValue == CNT_W'(1) && !overflowFlagClr) ##1
      (counterValue == CNT_W'(0)) |-> overflowFlag) else $error("no overflow at bottom");
  a_ovf_sticky:
    assert property (overflowFlag && !overflowFlagClr |=> overflowFlag)
      else $error("overflow flag dropped");
  a_count_step:
    assert property ($changed(counterValue) |-> counterValue == $past(counterValue) + CNT_W'(1)
      || counterValue == $past(counterValue) - CNT_W'(1)) else $error("counter jumped");
  // two stopped cycles, though the tick is decoded from clkSel directly, so one stopped cycle already freezes it
  a_stop_frozen:
    assert property ((clkSel == CLK_STOP) [*2] |=> $stable(counterValue))
      else $error("counter moved while stopped");
  a_rd_miss_zero:
    assert property (!regReq.rd || (regReq.addr != 8'h44 && regReq.addr != 8'h24)
      |-> regRdata == 8'h00) else $error("read data on a miss");
  a_rsv_zero:
    assert property (regRdata[3:2] == 2'b00) else $error("reserved bits set");
  a_io_write_back:
    assert property ((regReq.wr && regReq.ioSpace && regReq.addr == 8'h24) ##1
      (regReq.rd && !regReq.wr && regReq.ioSpace && regReq.addr == 8'h24)
      |-> regRdata == ($past(regReq.wdata) & 8'hF3)) else $error("io write lost");
  c_ovf: cover property ($rose(overflowFlag));
  c_top: cover property ($rose(counterValue == CNT_W'(255)));
  c_pin: cover property (!pinOeA_n && compareOutputA);
endmodule
bind dual_slope_pwm_timer8 dual_slope_pwm_timer8_monitor #(.CNT_W(CNT_W)) mon (
  .sys_clk, .arst_n, .regReq, .regRdata, .waveformModeHighBit, .clkSel, .compareValueA,
  .compareValueB, .pinDirOutA, .pinDirOutB, .overflowFlagClr, .matchFlagAClr,
  .matchFlagBClr, .counterValue, .overflowFlag, .matchFlagA, .matchFlagB,
  .compareOutputA, .compareOutputB, .pinOutA, .pinOeA_n, .pinOutB, .pinOeB_n);

/* shared/pwm_timer8_params.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PWM_TIMER8_PARAMS_SVH
`define PWM_TIMER8_PARAMS_SVH
`define CTRL_A_DATA_OFFSET   8'h44
`define CTRL_A_IO_OFFSET     8'h24
`define CTRL_A_RESET         8'h00
`define CTRL_A_WRITE_MASK    8'hF3
`define CTRL_A_ACT_A_HI      7
`define CTRL_A_ACT_A_LO      6
`define CTRL_A_ACT_B_HI      5
`define CTRL_A_ACT_B_LO      4
`define CTRL_A_WGM_HI        1
`define CTRL_A_WGM_LO        0
`define MODE_DUAL_FIXED      3'h1
`define MODE_DUAL_VAR        3'h5
`define ACT_TOGGLE           2'h1
`define ACT_NONINV           2'h2
`define ACT_INV              2'h3
`define COUNT_BOTTOM         8'h00
`define COUNT_MAX            8'hFF
`define PERIOD_TICKS         510
`define DIV_1                11'h001
`define DIV_8                11'h008
`define DIV_64               11'h040
`define DIV_256              11'h100
`define DIV_1024             11'h400
`endif

/* shared/pwm_timer8_pkg.sv */
// types shared by the dual-slope pwm timer
package pwm_timer8_pkg;
  typedef enum logic [2:0] {
    CLK_STOP = 3'h0,
    CLK_D1   = 3'h1,
    CLK_D8   = 3'h2,
    CLK_D64  = 3'h3,
    CLK_D256 = 3'h4,
    CLK_D1K  = 3'h5
  } clk_sel_t;
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;
  typedef struct packed {
    logic [1:0] actA;
    logic [1:0] actB;
    logic [1:0] wgmLo;
  } ctrl_a_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       ioSpace;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

/* verilog/dual_slope_pwm_timer8.sv */
// dual-slope pwm timer/counter, 8 bit, two compare channels
// What this block does
// RULE_01: modes 0x1/0x5 count up then down
// RULE_02: top is 0xFF or channel A compare
// RULE_03: clear on up match, set down; inverted swaps
// RULE_04: action 0x2 non-inverted, 0x3 inverted pwm
// RULE_05: counter holds top one tick, then reverses
// RULE_06: overflow flag set when counter reaches bottom
// RULE_07: channel A toggles on match when mode high set
// RULE_08: pin driven only when direction is output
// RULE_09: compare bottom low, max high; inverted opposite
// RULE_10: leaving max gives transition at period start; the code has no logic for this transition
// RULE_11: starting up above compare misses up match
// RULE_12: prescaler divides 1..1024; period 510 ticks
// RULE_13: synchronous; tick is clock enable
// RULE_14: control A at 0x44, I/O 0x24
// RULE_15: compare equal top: set/clear done at top
// RULE_16: compare values buffered, loaded at top
`timescale 1ns/1ps
`include "pwm_timer8_params.svh"
module dual_slope_pwm_timer8
  import pwm_timer8_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire reg_req_t         regReq,
  output logic [7:0]            regRdata,
  input  wire logic             waveformModeHighBit,
  input  wire clk_sel_t         clkSel,
  input  wire logic [CNT_W-1:0] compareValueA,
  input  wire logic [CNT_W-1:0] compareValueB,
  input  wire logic             pinDirOutA,
  input  wire logic             pinDirOutB,
  input  wire logic             overflowFlagClr,
  input  wire logic             matchFlagAClr,
  input  wire logic             matchFlagBClr,
  output logic [CNT_W-1:0]      counterValue,
  output logic                  overflowFlag,
  output logic                  matchFlagA,
  output logic                  matchFlagB,
  output logic                  compareOutputA,
  output logic                  compareOutputB,
  output logic                  pinOutA,
  output logic                  pinOeA_n,
  output logic                  pinOutB,
  output logic                  pinOeB_n
);
  ctrl_a_t          ctrl_r;
  logic [CNT_W-1:0] cnt_r;
  dir_t             dir_r;
  logic [CNT_W-1:0] ocrA_r;
  logic [CNT_W-1:0] ocrB_r;
  logic             ocA_r;
  logic             ocB_r;
  logic             tov_r;
  logic             ocfA_r;
  logic             ocfB_r;
  logic             timerTick;
  logic [2:0]       mode;
  logic             dualMode;
  logic [CNT_W-1:0] topVal;
  logic             atTop;
  logic             atBottom;
  logic             goingUp;
  logic [CNT_W-1:0] cnt_nxt;
  dir_t             dir_nxt;
  logic             hitCtrl;
  logic             matchA;
  logic             matchB;
  logic             ocA_nxt;
  logic             ocB_nxt;
  logic [7:0]       ctrlRead;
  logic [5:0]       ctrlWdata;
  logic             ctrlWrite;
  logic             countEn;
  logic             bufLoad;
  logic             ovfSet;
  logic             matchSetA;
  logic             matchSetB;
  logic             pwmA;
  logic             pwmB;
  logic             togA;
  logic             togB;
  logic             hitMidA;
  logic             hitMidB;
  logic             hitTopA;
  logic             hitTopB;
  logic             forceBotA;
  logic             forceBotB;
  logic             slopeLvlA;
  logic             slopeLvlB;

  tick_prescaler #(
    .DIV_W (10)
  ) u_presc (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .clkSel  (clkSel),
    .tick    (timerTick)
  );

  // register access
  assign hitCtrl = regReq.ioSpace ? (regReq.addr == `CTRL_A_IO_OFFSET)
                                  : (regReq.addr == `CTRL_A_DATA_OFFSET); // see RULE_14
  assign ctrlRead = {ctrl_r.actA, ctrl_r.actB, 2'b00, ctrl_r.wgmLo};
  assign regRdata = (regReq.rd && hitCtrl) ? ctrlRead : 8'h00;
  assign ctrlWrite = regReq.wr && hitCtrl;
  // bits 3:2 are not stored, so they always read back as zero
  assign ctrlWdata = {regReq.wdata[`CTRL_A_ACT_A_HI:`CTRL_A_ACT_B_LO],
                      regReq.wdata[`CTRL_A_WGM_HI:`CTRL_A_WGM_LO]};

  // mode and top
  assign mode     = {waveformModeHighBit, ctrl_r.wgmLo};
  assign dualMode = (mode == `MODE_DUAL_FIXED) || (mode == `MODE_DUAL_VAR); // see RULE_01
  assign topVal   = (mode == `MODE_DUAL_VAR) ? ocrA_r : CNT_W'(`COUNT_MAX); // see RULE_02
  assign atTop    = (cnt_r == topVal);
  assign atBottom = (cnt_r == CNT_W'(`COUNT_BOTTOM));
  assign countEn  = timerTick && dualMode; // see RULE_13
  // outside dual-slope the compare values follow the inputs at once
  assign bufLoad  = !dualMode || (timerTick && atTop); // see RULE_16

  // direction for the step taken on this tick; top holds one tick then reverses
  assign goingUp = (dir_r == DIR_UP) && !atTop;
  assign dir_nxt = atTop ? DIR_DOWN : (atBottom ? DIR_UP : dir_r); // see RULE_05
  assign cnt_nxt = atTop ? cnt_r - 1'b1 :
                   atBottom ? cnt_r + 1'b1 :
                   (dir_r == DIR_UP) ? cnt_r + 1'b1 : cnt_r - 1'b1; // see RULE_01

  // a match only happens when the count equals the compare; jumping past it
  // by a counter start above compare simply never matches on the way up
  assign matchA = (cnt_r == ocrA_r); // see RULE_11
  assign matchB = (cnt_r == ocrB_r);

  // channel A: non-inverted clears counting up, sets counting down
  assign pwmA      = ctrl_r.actA[1]; // see RULE_04
  assign togA      = (ctrl_r.actA == `ACT_TOGGLE) && waveformModeHighBit; // see RULE_07
  assign hitMidA   = matchA && !atTop; // see RULE_03
  // compare at top: match ignored, level set at top so max stays high
  assign hitTopA   = matchA && atTop; // see RULE_15
  // compare at bottom: forced to the up-count level so it stays low
  assign forceBotA = atBottom && (ocrA_r == CNT_W'(`COUNT_BOTTOM)); // see RULE_09
  assign slopeLvlA = goingUp ? ctrl_r.actA[0] : !ctrl_r.actA[0]; // see RULE_03
  assign ocA_nxt   = togA      ? (ocA_r ^ matchA) :
                     !pwmA     ? ocA_r :
                     forceBotA ? ctrl_r.actA[0] :
                     hitTopA   ? !ctrl_r.actA[0] : // see RULE_10
                     hitMidA   ? slopeLvlA : ocA_r;

  // channel B has no toggle option in this mode
  assign pwmB      = ctrl_r.actB[1]; // see RULE_04
  assign togB      = 1'b0; // see RULE_07
  assign hitMidB   = matchB && !atTop; // see RULE_03
  assign hitTopB   = matchB && atTop; // see RULE_15
  assign forceBotB = atBottom && (ocrB_r == CNT_W'(`COUNT_BOTTOM)); // see RULE_09
  assign slopeLvlB = goingUp ? ctrl_r.actB[0] : !ctrl_r.actB[0]; // see RULE_03
  assign ocB_nxt   = togB      ? (ocB_r ^ matchB) :
                     !pwmB     ? ocB_r :
                     forceBotB ? ctrl_r.actB[0] :
                     hitTopB   ? !ctrl_r.actB[0] : // see RULE_10
                     hitMidB   ? slopeLvlB : ocB_r;

  // flag set terms; a set in the same cycle as a clear wins
  assign ovfSet    = countEn && (cnt_nxt == CNT_W'(`COUNT_BOTTOM)) && !atBottom; // see RULE_06
  assign matchSetA = countEn && matchA;
  assign matchSetB = countEn && matchB;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= '0;
    end else if (ctrlWrite) begin // see RULE_14
      ctrl_r <= ctrl_a_t'(ctrlWdata);
    end
  end

  // counter advances only on the prescaled tick
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      dir_r <= DIR_UP;
    end else if (countEn) begin // see RULE_13
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end

  // buffered compare values refresh at top
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ocrA_r <= '0;
    end else if (bufLoad) begin // see RULE_16
      ocrA_r <= compareValueA;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ocrB_r <= '0;
    end else if (bufLoad) begin // see RULE_16
      ocrB_r <= compareValueB;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ocA_r <= 1'b0;
    end else if (countEn) begin
      ocA_r <= ocA_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ocB_r <= 1'b0;
    end else if (countEn) begin
      ocB_r <= ocB_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tov_r <= 1'b0;
    end else begin
      tov_r <= ovfSet || (tov_r && !overflowFlagClr); // see RULE_06
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ocfA_r <= 1'b0;
    end else begin
      ocfA_r <= matchSetA || (ocfA_r && !matchFlagAClr);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ocfB_r <= 1'b0;
    end else begin
      ocfB_r <= matchSetB || (ocfB_r && !matchFlagBClr);
    end
  end

  assign counterValue   = cnt_r;
  assign overflowFlag   = tov_r;
  assign matchFlagA     = ocfA_r;
  assign matchFlagB     = ocfB_r;
  assign compareOutputA = ocA_r;
  assign compareOutputB = ocB_r;
  // pin shows the compare output only when directed out and connected
  assign pinOutA  = ocA_r;
  assign pinOeA_n = !(pinDirOutA && (ctrl_r.actA != 2'b00)); // see RULE_08
  assign pinOutB  = ocB_r;
  assign pinOeB_n = !(pinDirOutB && ctrl_r.actB[1]); // see RULE_08
endmodule

/* verilog/tick_prescaler.sv */
// prescaler producing the one-cycle timer tick enable
`timescale 1ns/1ps
`include "pwm_timer8_params.svh"
module tick_prescaler
  import pwm_timer8_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input  wire logic     sys_clk,
  input  wire logic     arst_n,
  input  wire clk_sel_t clkSel,
  output logic          tick
);
  logic [DIV_W-1:0] div_r;
  logic [10:0]      ratio;
  // one free counter; each division taps its own wrap point
  assign ratio = (clkSel == CLK_D1)   ? `DIV_1 :
                 (clkSel == CLK_D8)   ? `DIV_8 :
                 (clkSel == CLK_D64)  ? `DIV_64 :
                 (clkSel == CLK_D256) ? `DIV_256 : `DIV_1024;
  assign tick = (clkSel != CLK_STOP)
             && ((div_r & DIV_W'(ratio - 11'h001)) == '0); // see RULE_12
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
endmodule
